// file: design/utlb_pkg.sv
// package: constants and carriers for the transceiver loopback control block
package utlb_pkg;
	// ==================================================
	// register offsets
	localparam logic [3:0] TDM_LOOP_CONTROL_REG = 4'h6;
	localparam logic [3:0] FRAMING_CONFIG_REG = 4'h8;
	localparam logic [3:0] BANK_SELECT_REG = 4'hA;
	localparam logic [3:0] FRAMER_TEST_CONTROL_REG = 4'hE;
	localparam logic [3:0] ACTIVATION_STATUS_REG = 4'h1;
	localparam logic [3:0] ACTIVATION_CONTROL_REG = 4'h2;
	localparam logic [3:0] OVERLAY_TEST_REG = 4'h9;
	// ==================================================
	// field positions
	localparam int LOOP_TRANSP_BIT = 0;
	localparam int LOOP_B1_BIT = 1;
	localparam int LOOP_B2_BIT = 2;
	localparam int LOOP_2BD_BIT = 3;
	localparam int F2D_LOOP_BIT = 4;
	localparam int LT_MODE_BIT = 0;
	// ==================================================
	// values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] OVERLAY_SELECT = 8'h01;
	localparam logic [7:0] EXT_LOOP_VALUE = 8'h20;
	localparam logic [7:0] NT_F2D_FRAMING = 8'hB7;
	localparam logic [3:0] READY_STATUS = 4'hB;
	// ==================================================
	// timing
	localparam int CLK_MHZ = 100;
	localparam int NT_TX_MIN_US = 196;
	localparam int NT_TX_MAX_US = 315;
	localparam int LT_TX_MIN_US = 184;
	localparam int LT_TX_MAX_US = 328;
	localparam int RX_MIN_US = 281;
	localparam int RX_MAX_US = 400;
	// tx delay chosen inside both NT and LT windows
	localparam int TX_DELAY_US = 256;
	localparam int RX_DELAY_US = 320;
	localparam int TX_DELAY_CYC = TX_DELAY_US * CLK_MHZ;
	localparam int RX_DELAY_CYC = RX_DELAY_US * CLK_MHZ;
	// ==================================================
	// carriers
	typedef struct packed {
		logic b1;
		logic b2;
		logic d;
		logic m;
	} utlb_chan_type;
endpackage

// file: design/utlb_delay.sv
// file: fixed transit delay line for single-bit stream samples
`timescale 1ns/1ps
module utlb_delay #(
	parameter int DEPTH = 25600
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// stream
	input wire logic strobe_in,
	input wire logic bit_in,
	output logic bit_out
);
	// ==================================================
	// circular buffer: one entry per link bit strobe
	localparam int AW = $clog2(DEPTH);
	logic mem [DEPTH];
	logic [AW-1:0] ptr_q, ptr_d;
	logic bit_q, bit_d;

	// pointer advance
	always_comb begin
		ptr_d = ptr_q;
		bit_d = bit_q;
		if (strobe_in) begin
			bit_d = mem[ptr_q];
			ptr_d = (ptr_q == AW'(DEPTH - 1)) ? '0 : ptr_q + 1'b1;
		end
	end

	// storage has no reset; unwritten entries read unknown until first pass is acceptable
	always_ff @(posedge core_clk_in) begin
		if (strobe_in)
			mem[ptr_q] <= bit_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ptr_q <= '0;
			bit_q <= 1'b1;
		end else begin
			ptr_q <= ptr_d;
			bit_q <= bit_d;
		end
	end

	assign bit_out = bit_q;
endmodule

// file: design/utlb_top.sv
// file: loopback control of a 2B1Q line transceiver
// Behaviour
// - loop select bits B1, B2, 2B+D return that channel toward the TDM bus
// - transparent bit set: input data also continues onto the line
// - transparent clear with a TDM loop: line data is all ones
// - framer test bit one enables framer-to-deframer loop, zero disables
// - that loop routes B, D, M framer output into deframer input
// - during that loop the line driver is disabled
// - that loop returns serial input and control data on outputs
// - device shows 0B in activation status when ready; controller polls
// - NT frame sync to line delay within 196..315 us
// - NT line to receive frame sync delay within 281..400 us
// - LT frame sync to line delay within 184..328 us
// - LT line to receive frame sync delay within 281..400 us
// - any combination of loop modes may be active together
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module utlb_top #(
	parameter int TX_DELAY = utlb_pkg::TX_DELAY_CYC / 40,
	parameter int RX_DELAY = utlb_pkg::RX_DELAY_CYC / 40
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// tdm serial bus pins
	input wire logic tdm_data_clock_in,
	input wire logic transmit_frame_sync_in,
	input wire logic tdm_din_in,
	input wire utlb_pkg::utlb_chan_type tdm_slot_in,
	output logic tdm_dout_out,
	output logic receive_frame_sync_out,
	// serial control port m channel
	input wire logic serial_control_port_in,
	output logic serial_control_port_out,
	// line side
	input wire logic line_rx_in,
	input wire logic line_sync_in,
	output logic line_tx_out,
	output logic line_tx_oe_n_out,
	// activation status from the activation engine; lt mode and external analog loop outputs
	input wire logic [3:0] act_status_in,
	output logic lt_mode_out,
	output logic ext_analog_loop_out
);
	// ==================================================
	// synchronisers for pin inputs
	logic [1:0] dcl_s1_q, dcl_s2_q;
	logic [1:0] fsx_s1_q, fsx_s2_q;
	logic [1:0] din_s1_q, din_s2_q;
	logic [1:0] scp_s1_q, scp_s2_q;
	logic [1:0] lrx_s1_q, lrx_s2_q;
	logic [1:0] lsy_s1_q, lsy_s2_q;
	logic [3:0] slot_s1_q, slot_s2_q;
	logic dcl_prev_q;

	// two flops per pin; only stage two is read
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			dcl_s1_q <= '0;
			dcl_s2_q <= '0;
			fsx_s1_q <= '0;
			fsx_s2_q <= '0;
			din_s1_q <= '1;
			din_s2_q <= '1;
			scp_s1_q <= '1;
			scp_s2_q <= '1;
			lrx_s1_q <= '1;
			lrx_s2_q <= '1;
			lsy_s1_q <= '0;
			lsy_s2_q <= '0;
			slot_s1_q <= '0;
			slot_s2_q <= '0;
			dcl_prev_q <= 1'b0;
		end else begin
			dcl_s1_q <= {1'b0, tdm_data_clock_in};
			dcl_s2_q <= dcl_s1_q;
			fsx_s1_q <= {1'b0, transmit_frame_sync_in};
			fsx_s2_q <= fsx_s1_q;
			din_s1_q <= {1'b1, tdm_din_in};
			din_s2_q <= din_s1_q;
			scp_s1_q <= {1'b1, serial_control_port_in};
			scp_s2_q <= scp_s1_q;
			lrx_s1_q <= {1'b1, line_rx_in};
			lrx_s2_q <= lrx_s1_q;
			lsy_s1_q <= {1'b0, line_sync_in};
			lsy_s2_q <= lsy_s1_q;
			slot_s1_q <= tdm_slot_in;
			slot_s2_q <= slot_s1_q;
			dcl_prev_q <= dcl_s2_q[0];
		end
	end

	logic dcl_rise;
	logic transmit_frame_sync;
	logic din;
	logic serial_control_port;
	logic lrx;
	logic lsy;
	utlb_pkg::utlb_chan_type slot;
	assign dcl_rise = dcl_s2_q[0] & ~dcl_prev_q;
	assign transmit_frame_sync = fsx_s2_q[0];
	assign din = din_s2_q[0];
	assign serial_control_port = scp_s2_q[0];
	assign lrx = lrx_s2_q[0];
	assign lsy = lsy_s2_q[0];
	assign slot = slot_s2_q;

	// ==================================================
	// register file
	logic [7:0] loop_ctl_q, loop_ctl_d;
	logic [7:0] framing_q, framing_d;
	logic [7:0] bank_q, bank_d;
	logic [7:0] ftest_q, ftest_d;
	logic [7:0] actctl_q, actctl_d;
	logic [7:0] ovl_test_q, ovl_test_d;
	logic [7:0] rdata_q, rdata_d;
	logic ovl_sel;
	assign ovl_sel = (bank_q == utlb_pkg::OVERLAY_SELECT);

	// decode writes and reads; overlay map hides normal map
	always_comb begin
		loop_ctl_d = loop_ctl_q;
		framing_d = framing_q;
		bank_d = bank_q;
		ftest_d = ftest_q;
		actctl_d = actctl_q;
		ovl_test_d = ovl_test_q;
		rdata_d = 8'h00;
		if (reg_wr_in) begin
			if (reg_addr_in == utlb_pkg::BANK_SELECT_REG)
				bank_d = reg_wdata_in;
			else if (ovl_sel) begin
				if (reg_addr_in == utlb_pkg::OVERLAY_TEST_REG)
					ovl_test_d = reg_wdata_in;
			end else begin
				case (reg_addr_in)
					utlb_pkg::TDM_LOOP_CONTROL_REG: loop_ctl_d = reg_wdata_in;
					utlb_pkg::FRAMING_CONFIG_REG: framing_d = reg_wdata_in;
					utlb_pkg::FRAMER_TEST_CONTROL_REG: ftest_d = reg_wdata_in;
					utlb_pkg::ACTIVATION_CONTROL_REG: actctl_d = reg_wdata_in;
					default: ;
				endcase
			end
		end
		if (reg_rd_in) begin
			if (reg_addr_in == utlb_pkg::BANK_SELECT_REG)
				rdata_d = bank_q;
			else if (ovl_sel) begin
				if (reg_addr_in == utlb_pkg::OVERLAY_TEST_REG)
					rdata_d = ovl_test_q;
			end else begin
				case (reg_addr_in)
					utlb_pkg::TDM_LOOP_CONTROL_REG: rdata_d = loop_ctl_q;
					utlb_pkg::FRAMING_CONFIG_REG: rdata_d = framing_q;
					utlb_pkg::FRAMER_TEST_CONTROL_REG: rdata_d = ftest_q;
					utlb_pkg::ACTIVATION_CONTROL_REG: rdata_d = actctl_q;
					utlb_pkg::ACTIVATION_STATUS_REG: rdata_d = {4'h0, act_status_in};
					default: rdata_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			loop_ctl_q <= utlb_pkg::REG_RESET;
			framing_q <= utlb_pkg::REG_RESET;
			bank_q <= utlb_pkg::REG_RESET;
			ftest_q <= utlb_pkg::REG_RESET;
			actctl_q <= utlb_pkg::REG_RESET;
			ovl_test_q <= utlb_pkg::REG_RESET;
			rdata_q <= 8'h00;
		end else begin
			loop_ctl_q <= loop_ctl_d;
			framing_q <= framing_d;
			bank_q <= bank_d;
			ftest_q <= ftest_d;
			actctl_q <= actctl_d;
			ovl_test_q <= ovl_test_d;
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata_out = rdata_q;

	// ==================================================
	// loop decisions; all modes are independent bits except the external analog loop, a whole overlay byte compare
	logic loop_b1, loop_b2, loop_2bd, transp, f2d_en, tdm_loop;
	assign loop_b1 = loop_ctl_q[utlb_pkg::LOOP_B1_BIT];
	assign loop_b2 = loop_ctl_q[utlb_pkg::LOOP_B2_BIT];
	assign loop_2bd = loop_ctl_q[utlb_pkg::LOOP_2BD_BIT];
	assign transp = loop_ctl_q[utlb_pkg::LOOP_TRANSP_BIT];
	assign f2d_en = ftest_q[utlb_pkg::F2D_LOOP_BIT];
	assign tdm_loop = loop_b1 | loop_b2 | loop_2bd;
	assign lt_mode_out = framing_q[utlb_pkg::LT_MODE_BIT];
	assign ext_analog_loop_out = (ovl_test_q == utlb_pkg::EXT_LOOP_VALUE);

	// which channel the current bit belongs to decides the tdm loop
	logic slot_looped;
	assign slot_looped = (loop_2bd & (slot.b1 | slot.b2 | slot.d))
		| (loop_b1 & slot.b1) | (loop_b2 & slot.b2);

	// ==================================================
	// transit delay lines: framer path and deframer path
	logic tx_in_bit, tx_del_bit, rx_in_bit, rx_del_bit;
	logic m_in_bit;
	assign m_in_bit = serial_control_port;

	// line gets idle ones unless transparent or no tdm loop
	assign tx_in_bit = (tdm_loop & ~transp) ? 1'b1 : din;

	utlb_delay #(.DEPTH(TX_DELAY)) u_tx_delay (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.strobe_in(dcl_rise),
		.bit_in(tx_in_bit),
		.bit_out(tx_del_bit)
	);

	// framer output feeds deframer directly in framer loop
	assign rx_in_bit = f2d_en ? tx_del_bit : lrx;

	utlb_delay #(.DEPTH(RX_DELAY)) u_rx_delay (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.strobe_in(dcl_rise),
		.bit_in(rx_in_bit),
		.bit_out(rx_del_bit)
	);

	// ==================================================
	// output registers
	logic dout_q, dout_d, ltx_q, ltx_d, oen_q, oen_d, scpo_q, scpo_d, fsr_q, fsr_d;
	logic m_q, m_d;

	// tdm loop wins for its slots; otherwise deframed data returns
	always_comb begin
		dout_d = dout_q;
		m_d = m_q;
		scpo_d = scpo_q;
		if (dcl_rise) begin
			dout_d = slot_looped ? din : rx_del_bit;
			m_d = m_in_bit;
			scpo_d = f2d_en ? m_q : 1'b1;
		end
		ltx_d = tx_del_bit;
		oen_d = f2d_en;
		fsr_d = lsy;
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			dout_q <= 1'b1;
			m_q <= 1'b1;
			scpo_q <= 1'b1;
			ltx_q <= 1'b1;
			oen_q <= 1'b1;
			fsr_q <= 1'b0;
		end else begin
			dout_q <= dout_d;
			m_q <= m_d;
			scpo_q <= scpo_d;
			ltx_q <= ltx_d;
			oen_q <= oen_d;
			fsr_q <= fsr_d;
		end
	end

	assign tdm_dout_out = dout_q;
	assign serial_control_port_out = scpo_q;
	assign line_tx_out = ltx_q;
	assign line_tx_oe_n_out = oen_q;
	assign receive_frame_sync_out = fsr_q;

	// ==================================================
	// checks
	// framer loop: driver, routing, enable bit, control port return
	a_driver_off_f2d: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) f2d_en |=> line_tx_oe_n_out)
		else $error("line driver active during framer loop");
	a_driver_on: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) !f2d_en |=> !line_tx_oe_n_out)
		else $error("line driver off outside framer loop");
	a_f2d_route: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) f2d_en |-> (rx_in_bit == tx_del_bit))
		else $error("deframer not fed from framer");
	a_f2d_write: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(reg_wr_in && !ovl_sel && reg_addr_in == utlb_pkg::FRAMER_TEST_CONTROL_REG)
		|=> (f2d_en == $past(reg_wdata_in[utlb_pkg::F2D_LOOP_BIT])))
		else $error("framer loop enable not written");
	a_scp_return: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(dcl_rise && f2d_en) |=> (serial_control_port_out == $past(m_q)))
		else $error("m data not returned");
	a_scp_idle: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(dcl_rise && !f2d_en) |=> serial_control_port_out)
		else $error("control port not idle outside framer loop");

	// tdm loops and line data
	a_idle_ones_line: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) (tdm_loop && !transp) |-> tx_in_bit)
		else $error("line data not idle in opaque loop");
	a_transp_pass: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) (tdm_loop && transp) |-> (tx_in_bit == din))
		else $error("transparent loop blocks input");
	a_loop_return: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(dcl_rise && slot_looped) |=> (tdm_dout_out == $past(din)))
		else $error("looped slot not returned");
	a_dout_stands: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) !dcl_rise |=> $stable(tdm_dout_out))
		else $error("serial output moved between bits");

	// register port: overlay gate, status view, one-cycle read data
	a_overlay_gate: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(reg_wr_in && !ovl_sel && reg_addr_in == utlb_pkg::OVERLAY_TEST_REG)
		|=> $stable(ext_analog_loop_out))
		else $error("overlay written without select");
	a_overlay_select: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(reg_wr_in && ovl_sel && reg_addr_in == utlb_pkg::OVERLAY_TEST_REG
		&& reg_wdata_in == utlb_pkg::EXT_LOOP_VALUE) |=> ext_analog_loop_out)
		else $error("overlay write lost under select");
	a_status_read: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in)
		(reg_rd_in && !ovl_sel && reg_addr_in == utlb_pkg::ACTIVATION_STATUS_REG)
		|=> (reg_rdata_out == {4'h0, $past(act_status_in)}))
		else $error("status read wrong");
	a_rdata_one_cycle: assert property (@(posedge core_clk_in)
		disable iff (sys_rst_in) !reg_rd_in |=> (reg_rdata_out == 8'h00))
		else $error("read data outside its cycle");
endmodule

// file: verif/utlb_tdm_partner.sv
// tdm controller and line far side model driving the loopback block
`timescale 1ns/1ps
module utlb_tdm_partner (
	// data choice from the bench
	input wire logic hold_in,
	input wire logic hold_val_in,
	// tdm bus side
	output logic dcl_out,
	output logic fsx_out,
	output logic din_out,
	output logic scp_out,
	output utlb_pkg::utlb_chan_type slot_out,
	// line side
	output logic line_rx_out,
	output logic line_sync_out
);
	logic [3:0] cnt_q;

	// ==================================================
	// data clock, free running, this model is the bus master
	initial begin
		dcl_out = 1'b0;
		forever #40 dcl_out = ~dcl_out;
	end

	// ==================================================
	// new bits on the rising pin edge so they settle before the sampled edge
	initial begin
		cnt_q = 4'h0;
		fsx_out = 1'b0;
		din_out = 1'b1;
		scp_out = 1'b1;
		slot_out = 4'h0;
		line_rx_out = 1'b1;
		line_sync_out = 1'b0;
	end

	// fixed slot plan: b1, b2, d, m in quarters of sixteen bits
	always @(posedge dcl_out) begin
		cnt_q <= cnt_q + 4'h1;
		slot_out.b1 <= (cnt_q[3:2] == 2'h0);
		slot_out.b2 <= (cnt_q[3:2] == 2'h1);
		slot_out.d <= (cnt_q[3:2] == 2'h2);
		slot_out.m <= (cnt_q[3:2] == 2'h3);
		fsx_out <= (cnt_q == 4'hF);
		line_sync_out <= (cnt_q == 4'hF);
		din_out <= hold_in ? hold_val_in : 1'($urandom);
		scp_out <= hold_in ? hold_val_in : 1'($urandom);
		line_rx_out <= 1'($urandom);
	end
endmodule

// file: verif/u_transceiver_loopback_ctrl_tb.sv
// testbench: loopback control block against the tdm controller model
`timescale 1ns/1ps
module u_transceiver_loopback_ctrl_tb;
	// ==================================================
	// signals
	logic clk, rst, wr, rd, hold, hold_val, loop_on, seen0, delay_chk;
	logic [8:0] hist;
	logic [3:0] addr, status;
	logic [7:0] wdata, rdata, v;
	logic [2:0] sel;
	logic tdm_data_clock, transmit_frame_sync, din, scp_i, scp_o, lrx, lsync, dout, receive_frame_sync, ltx, oe_n, lt, ext;
	utlb_pkg::utlb_chan_type slot;
	int miscompares, comparisons, cycles;

	// single instance: one transceiver under loop test at a time
	utlb_top #(.TX_DELAY(8), .RX_DELAY(8)) DUT (.core_clk_in(clk), .sys_rst_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .tdm_data_clock_in(tdm_data_clock), .transmit_frame_sync_in(transmit_frame_sync),
		.tdm_din_in(din), .tdm_slot_in(slot), .tdm_dout_out(dout),
		.receive_frame_sync_out(receive_frame_sync), .serial_control_port_in(scp_i),
		.serial_control_port_out(scp_o), .line_rx_in(lrx), .line_sync_in(lsync),
		.line_tx_out(ltx), .line_tx_oe_n_out(oe_n), .act_status_in(status),
		.lt_mode_out(lt), .ext_analog_loop_out(ext));
	utlb_tdm_partner far_end (.hold_in(hold), .hold_val_in(hold_val), .dcl_out(tdm_data_clock),
		.fsx_out(transmit_frame_sync), .din_out(din), .scp_out(scp_i), .slot_out(slot),
		.line_rx_out(lrx), .line_sync_out(lsync));

	// ==================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	// ==================================================
	// shared tasks
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata === e, "register read value");
	endtask
	task automatic wait_bits(input int n);
		repeat (n) @(posedge tdm_data_clock);
	endtask
	task automatic end_of_test();
		$display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==================================================
	// which slots a set of loop selects returns toward the tdm bus
	function automatic logic slot_is_looped(input logic [2:0] s,
		input utlb_pkg::utlb_chan_type c);
		return (s[0] && c.b1) || (s[1] && c.b2) || (s[2] && (c.b1 || c.b2 || c.d));
	endfunction

	// looped slots must return the bit just presented; old din seen before its update
	// line bit must be the input bit from eight link bits back (bench delay depth)
	always @(posedge tdm_data_clock) begin
		hist = {hist[7:0], din};
		if (ltx === 1'b0) seen0 = 1'b1;
		if (loop_on && slot_is_looped(sel, slot)) begin
			check(dout === din, "looped bit returned");
		end
		if (delay_chk) begin
			check(ltx === hist[8], "line transit delay");
			check(receive_frame_sync === lsync, "receive frame sync");
		end
	end

	// ==================================================
	// main sequence
	initial begin
		rst = 1'b1;
		{wr, rd, hold, hold_val, loop_on, seen0, delay_chk} = 7'h00;
		addr = 4'h0;
		wdata = 8'h00;
		sel = 3'h0;
		status = 4'h0;
		void'($urandom(43));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// sampled while the last reset edge still holds every output
		#1;
		check(rdata === 8'h00 && dout === 1'b1 && scp_o === 1'b1 && ltx === 1'b1 &&
			oe_n === 1'b1 && receive_frame_sync === 1'b0, "reset levels");
		v = 8'($urandom_range(15));
		wr_reg(utlb_pkg::TDM_LOOP_CONTROL_REG, v);
		rd_reg(utlb_pkg::TDM_LOOP_CONTROL_REG, v);
		rd_reg(4'h3, 8'h00);
		$display("test registers done");
		// each loop select alone, transparent
		for (int i = 0; i < 3; i++) begin
			wr_reg(utlb_pkg::TDM_LOOP_CONTROL_REG, 8'h01 | (8'h02 << i));
			sel = 3'h1 << i;
			wait_bits(12);
			seen0 = 1'b0;
			loop_on = 1'b1;
			delay_chk = 1'b1;
			wait_bits(32);
			loop_on = 1'b0;
			delay_chk = 1'b0;
			check(seen0 === 1'b1, "transparent line data");
		end
		// all loops, opaque: line idles at ones
		wr_reg(utlb_pkg::TDM_LOOP_CONTROL_REG, 8'h0E);
		sel = 3'h7;
		wait_bits(12);
		seen0 = 1'b0;
		loop_on = 1'b1;
		wait_bits(32);
		loop_on = 1'b0;
		check(seen0 === 1'b0, "opaque line ones");
		$display("test tdm loops done");
		// framer loop together with a transparent b1 loop
		wr_reg(utlb_pkg::FRAMING_CONFIG_REG, utlb_pkg::NT_F2D_FRAMING);
		rd_reg(utlb_pkg::FRAMING_CONFIG_REG, utlb_pkg::NT_F2D_FRAMING);
		wr_reg(utlb_pkg::TDM_LOOP_CONTROL_REG, 8'h03);
		wr_reg(utlb_pkg::FRAMER_TEST_CONTROL_REG, 8'h10);
		sel = 3'h1;
		loop_on = 1'b1;
		for (int k = 0; k < 2; k++) begin
			hold = 1'b1;
			hold_val = k[0];
			wait_bits(40);
			@(posedge clk);
			check(oe_n === 1'b1, "line driver off");
			check(dout === k[0] && scp_o === k[0], "framer loop returns data");
		end
		loop_on = 1'b0;
		hold = 1'b0;
		wr_reg(utlb_pkg::FRAMER_TEST_CONTROL_REG, 8'h00);
		repeat (4) @(posedge clk);
		check(oe_n === 1'b0, "line driver back on");
		$display("test framer loop done");
		// external analog loop set up, readiness, teardown
		wr_reg(utlb_pkg::FRAMING_CONFIG_REG, 8'h01);
		repeat (20) @(posedge clk); // shortened settle wait
		check(lt === 1'b1, "lt mode level");
		wr_reg(utlb_pkg::BANK_SELECT_REG, utlb_pkg::OVERLAY_SELECT);
		wr_reg(utlb_pkg::OVERLAY_TEST_REG, utlb_pkg::EXT_LOOP_VALUE);
		rd_reg(utlb_pkg::OVERLAY_TEST_REG, utlb_pkg::EXT_LOOP_VALUE);
		wr_reg(utlb_pkg::BANK_SELECT_REG, 8'h00);
		rd_reg(utlb_pkg::OVERLAY_TEST_REG, 8'h00);
		check(ext === 1'b1, "external loop on");
		wr_reg(utlb_pkg::ACTIVATION_CONTROL_REG, 8'h01);
		rd_reg(utlb_pkg::ACTIVATION_CONTROL_REG, 8'h01);
		@(posedge clk);
		status <= utlb_pkg::READY_STATUS;
		rd_reg(utlb_pkg::ACTIVATION_STATUS_REG, {4'h0, utlb_pkg::READY_STATUS});
		wr_reg(utlb_pkg::BANK_SELECT_REG, utlb_pkg::OVERLAY_SELECT);
		wr_reg(utlb_pkg::OVERLAY_TEST_REG, 8'h00);
		wr_reg(utlb_pkg::BANK_SELECT_REG, 8'h00);
		@(posedge clk);
		check(ext === 1'b0, "external loop off");
		// a write to the overlay offset with the overlay deselected must not land
		wr_reg(utlb_pkg::OVERLAY_TEST_REG, utlb_pkg::EXT_LOOP_VALUE);
		#1;
		check(ext === 1'b0, "overlay closed without select");
		$display("test external loop done");
		end_of_test();
	end
endmodule
